/* hdl/multifunction_pin_config.sv */
// Multifunction pin configuration: APB registers and registered pin controls
//
// Contract
// - Function 0 unused,1 output,2 alert,3 analog
// - Option meaning depends on selected function
// - Option 5 sets alert polarity only
// - Option 3 selects high drive rail
// - Option 1 tri-state or drive high
// - Option 0 pull-down, option 2 pull-up
// - Analog options 5:4 select pull-up
// - Analog options 3:2 select conversion model
// - Analog options 1:0 select measurement purpose
// - Sense pin: 0-2 unused, 3 analog
// - Sense pin setting resets to 0x07
// - Interrupt pin setting resets to 0x00
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_cfg.svh"

module multifunction_pin_config
	import pin_config_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt pin controls
	output logic intDriveLow,
	output logic intDriveHigh,
	output logic intHighFromReg1,
	output logic intWeakPullUp,
	output logic intWeakPullDown,
	output logic intAnalogEnable,
	output logic [1:0] intPullupSel,
	output logic [1:0] intPolySel,
	output logic [1:0] intMeasUse,
	output logic intSingleWireEnable,
	// Sense pin one controls
	output logic ts1AnalogEnable,
	output logic [1:0] ts1PullupSel,
	output logic [1:0] ts1PolySel,
	output logic [1:0] ts1MeasUse
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] intPinSetting;
	logic [7:0] ts1PinSetting;
	// Drive requests: bit 0 general level, bit 1 alert active
	logic [1:0] driveCtrl;

	function automatic logic [31:0] widen(input logic [7:0] v);
		widen = {24'h000000, v};
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire logic access = psel && penable;
	wire logic hitInt = (paddr == `OFS_INT_PIN);
	wire logic hitTs1 = (paddr == `OFS_TS1_PIN);
	wire logic hitIntSt = (paddr == `OFS_INT_STATUS);
	wire logic hitTs1St = (paddr == `OFS_TS1_STATUS);
	wire logic hitCtrl = (paddr == `OFS_DRIVE_CTRL);
	wire logic hitAny = hitInt || hitTs1 || hitIntSt || hitTs1St || hitCtrl;
	wire logic wrInt = access && pwrite && hitInt && !pready;
	wire logic wrTs1 = access && pwrite && hitTs1 && !pready;
	wire logic wrCtrl = access && pwrite && hitCtrl && !pready;

	// Decoded controls from both pins
	logic dIntLow, dIntHigh, dIntReg1, dIntPu, dIntPd, dIntAn;
	pullup_sel_t dIntPuSel, dTs1PuSel;
	poly_sel_t dIntPoly, dTs1Poly;
	meas_use_t dIntUse, dTs1Use;
	logic dTs1An;

	// Status word: unregistered decoder outputs of each pin
	wire logic [7:0] intStatus = {dIntPuSel, dIntAn, dIntPd, dIntPu, dIntReg1, dIntHigh, dIntLow};
	wire logic [7:0] ts1Status = {1'b0, dTs1An, dTs1Use, dTs1Poly, dTs1PuSel};

	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = 32'h00000000;
		if (hitInt) begin
			next_prdata = widen(intPinSetting);
		end else if (hitTs1) begin
			next_prdata = widen(ts1PinSetting);
		end else if (hitIntSt) begin
			next_prdata = widen(intStatus);
		end else if (hitTs1St) begin
			next_prdata = widen(ts1Status);
		end else if (hitCtrl) begin
			next_prdata = {30'h00000000, driveCtrl};
		end
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && !hitAny;
			prdata <= (access && !pready && !pwrite) ? next_prdata : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Setting registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			intPinSetting <= `INT_PIN_RESET;
			ts1PinSetting <= `TS1_PIN_RESET;
			driveCtrl <= 2'b00;
		end else begin
			if (wrInt) begin
				intPinSetting <= pwdata[7:0];
			end
			if (wrTs1) begin
				ts1PinSetting <= pwdata[7:0];
			end
			if (wrCtrl) begin
				driveCtrl <= pwdata[1:0];
			end
		end
	end

	// ----------------------------------------
	// Option decoders
	// ----------------------------------------
	pin_drive_decode intDecode (
		.setting(intPinSetting),
		.alertCapable(1'b1),
		.generalLevel(driveCtrl[0]),
		.alertActive(driveCtrl[1]),
		.driveLow(dIntLow),
		.driveHigh(dIntHigh),
		.highFromReg1(dIntReg1),
		.weakPullUp(dIntPu),
		.weakPullDown(dIntPd),
		.analogEnable(dIntAn),
		.pullupSel(dIntPuSel),
		.polySel(dIntPoly),
		.measUse(dIntUse)
	);

	pin_drive_decode ts1Decode (
		.setting(ts1PinSetting),
		.alertCapable(1'b0),
		.generalLevel(1'b0),
		.alertActive(1'b0),
		.driveLow(),
		.driveHigh(),
		.highFromReg1(),
		.weakPullUp(),
		.weakPullDown(),
		.analogEnable(dTs1An),
		.pullupSel(dTs1PuSel),
		.polySel(dTs1Poly),
		.measUse(dTs1Use)
	);

	// ----------------------------------------
	// Registered pin controls
	// ----------------------------------------
	wire pin_fn_t intFn = pin_fn_t'(intPinSetting[`FXN_MSB:`FXN_LSB]);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			intDriveLow <= 1'b0;
			intDriveHigh <= 1'b0;
			intHighFromReg1 <= 1'b0;
			intWeakPullUp <= 1'b0;
			intWeakPullDown <= 1'b0;
			intAnalogEnable <= 1'b0;
			intPullupSel <= PU_NONE;
			intPolySel <= POLY_18K;
			intMeasUse <= USE_GENERAL;
			intSingleWireEnable <= 1'b1;
		end else begin
			intDriveLow <= dIntLow;
			intDriveHigh <= dIntHigh;
			intHighFromReg1 <= dIntReg1;
			intWeakPullUp <= dIntPu;
			intWeakPullDown <= dIntPd;
			intAnalogEnable <= dIntAn;
			intPullupSel <= dIntPuSel;
			intPolySel <= dIntAn ? dIntPoly : POLY_18K;
			intMeasUse <= dIntAn ? dIntUse : USE_GENERAL;
			intSingleWireEnable <= (intFn == FN_UNUSED);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ts1AnalogEnable <= 1'b0;
			ts1PullupSel <= PU_NONE;
			ts1PolySel <= POLY_18K;
			ts1MeasUse <= USE_GENERAL;
		end else begin
			ts1AnalogEnable <= dTs1An;
			ts1PullupSel <= dTs1PuSel;
			ts1PolySel <= dTs1An ? dTs1Poly : POLY_18K;
			ts1MeasUse <= dTs1An ? dTs1Use : USE_GENERAL;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence intSetToFn(logic [1:0] f);
		intPinSetting[1:0] == f;
	endsequence

	unused_no_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
		intSetToFn(2'b00) ##1 intSetToFn(2'b00) |-> !intDriveLow && !intDriveHigh)
		else $error("unused pin driven");

	alert_polarity_a: assert property (@(posedge mclk) disable iff (!resetn)
		(intFn == FN_ALERT) && (intPinSetting[7] == driveCtrl[1])
		##1 $stable(intPinSetting) && $stable(driveCtrl) |-> intDriveLow)
		else $error("alert polarity wrong");

	general_no_polarity_a: assert property (@(posedge mclk) disable iff (!resetn)
		(intFn == FN_GENERAL_OUT) && driveCtrl[0] && intPinSetting[7]
		##1 $stable(intPinSetting) && $stable(driveCtrl) |-> !intDriveLow)
		else $error("general output inverted");

	regulator_one_rail_no_tristate_a: assert property (@(posedge mclk) disable iff (!resetn)
		intHighFromReg1 |-> !(intDriveLow == 1'b0 && intDriveHigh == 1'b0
		&& $past(intFn) != FN_UNUSED && $past(intFn) != FN_ANALOG))
		else $error("tri-state with regulator rail");

	rail_select_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(intFn) == FN_GENERAL_OUT |-> intHighFromReg1 == $past(intPinSetting[5]))
		else $error("rail select wrong");

	pulls_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(intFn) == FN_ALERT |-> intWeakPullDown == $past(intPinSetting[2])
		&& intWeakPullUp == $past(intPinSetting[4]))
		else $error("weak pull mismatch");

	ts1_unused_a: assert property (@(posedge mclk) disable iff (!resetn)
		ts1PinSetting[1:0] != 2'b11 |=> !ts1AnalogEnable)
		else $error("sense pin analog when unused");

	analog_pullup_a: assert property (@(posedge mclk) disable iff (!resetn)
		intFn == FN_ANALOG |=> intPullupSel == $past(intPinSetting[7:6]))
		else $error("pull-up select wrong");

	analog_model_a: assert property (@(posedge mclk) disable iff (!resetn)
		ts1PinSetting[1:0] == 2'b11 |=> ts1PolySel == $past(ts1PinSetting[5:4]))
		else $error("model select wrong");

	analog_use_a: assert property (@(posedge mclk) disable iff (!resetn)
		intFn == FN_ANALOG |=> intMeasUse == $past(intPinSetting[3:2]) && intAnalogEnable)
		else $error("measurement use wrong");

	reset_values_a: assert property (@(posedge mclk)
		$past(!resetn) |-> ts1PinSetting == 8'h07 && intPinSetting == 8'h00)
		else $error("reset value wrong");

	// ----------------------------------------
	// Bus response and idle-state checks
	// ----------------------------------------
	// First access cycle, before the wait state ends
	sequence apbTaken;
		psel && penable && !pready;
	endsequence

	// Ready stands for exactly one cycle
	sequence apbAnswer;
		pready ##1 !pready;
	endsequence

	ready_after_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
		apbTaken |=> apbAnswer)
		else $error("ready not after one wait state");

	error_with_ready_a: assert property (@(posedge mclk) disable iff (!resetn)
		pslverr |-> pready)
		else $error("error without ready");

	idle_data_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
		!pready |-> prdata == 32'h00000000)
		else $error("read data outside answer");

	int_write_lands_a: assert property (@(posedge mclk) disable iff (!resetn)
		wrInt |=> intPinSetting == $past(pwdata[7:0]))
		else $error("interrupt setting write lost");

	ts1_write_lands_a: assert property (@(posedge mclk) disable iff (!resetn)
		wrTs1 |=> ts1PinSetting == $past(pwdata[7:0]))
		else $error("sense setting write lost");

	ctrl_write_lands_a: assert property (@(posedge mclk) disable iff (!resetn)
		wrCtrl |=> driveCtrl == $past(pwdata[1:0]))
		else $error("drive control write lost");

	miss_write_ignored_a: assert property (@(posedge mclk) disable iff (!resetn)
		access && !pready && !hitAny |=> $stable(intPinSetting) && $stable(ts1PinSetting)
		&& $stable(driveCtrl))
		else $error("unmapped write changed state");

	unused_no_pulls_a: assert property (@(posedge mclk) disable iff (!resetn)
		intFn == FN_UNUSED |=> !intWeakPullUp && !intWeakPullDown && !intHighFromReg1)
		else $error("unused pin has output options");

	analog_no_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
		intFn == FN_ANALOG |=> !intDriveLow && !intDriveHigh && !intWeakPullUp
		&& !intWeakPullDown)
		else $error("analog pin driven");

	tristate_high_a: assert property (@(posedge mclk) disable iff (!resetn)
		(intFn == FN_GENERAL_OUT) && driveCtrl[0] && !intPinSetting[3] && !intPinSetting[5]
		|=> !intDriveLow && !intDriveHigh)
		else $error("tri-state high not released");

	alert_active_high_a: assert property (@(posedge mclk) disable iff (!resetn)
		(intFn == FN_ALERT) && !intPinSetting[7] && driveCtrl[1]
		&& (intPinSetting[3] || intPinSetting[5]) |=> intDriveHigh)
		else $error("active-high alert not driven");

	single_wire_a: assert property (@(posedge mclk) disable iff (!resetn)
		1'b1 |=> intSingleWireEnable == ($past(intFn) == FN_UNUSED))
		else $error("single-wire enable wrong");

	ts1_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
		ts1PinSetting[1:0] != 2'b11 |=> ts1PullupSel == PU_NONE && ts1PolySel == POLY_18K
		&& ts1MeasUse == USE_GENERAL)
		else $error("idle sense pin not idle");

	int_idle_model_a: assert property (@(posedge mclk) disable iff (!resetn)
		intFn != FN_ANALOG |=> intPullupSel == PU_NONE && intPolySel == POLY_18K
		&& intMeasUse == USE_GENERAL)
		else $error("analog options leak to output mode");

	ts1_use_a: assert property (@(posedge mclk) disable iff (!resetn)
		ts1PinSetting[1:0] == 2'b11 |=> ts1MeasUse == $past(ts1PinSetting[3:2])
		&& ts1PullupSel == $past(ts1PinSetting[7:6]))
		else $error("sense pin purpose wrong");
endmodule
`default_nettype wire

/* hdl/pin_config_cfg.svh */
// Register offsets, field positions and reset values of the pin configuration block
`ifndef PIN_CONFIG_CFG_SVH
`define PIN_CONFIG_CFG_SVH

`define OFS_INT_PIN 12'h000
`define OFS_TS1_PIN 12'h004
`define OFS_INT_STATUS 12'h008
`define OFS_TS1_STATUS 12'h00c
`define OFS_DRIVE_CTRL 12'h010

`define FXN_LSB 0
`define FXN_MSB 1
`define OPT_LSB 2
`define OPT_MSB 7

`define INT_PIN_RESET 8'h00
`define TS1_PIN_RESET 8'h07

`endif

/* hdl/pin_config_pkg.sv */
// Types for the pin configuration block
package pin_config_pkg;
	typedef enum logic [1:0] {
		FN_UNUSED = 2'b00,
		FN_GENERAL_OUT = 2'b01,
		FN_ALERT = 2'b10,
		FN_ANALOG = 2'b11
	} pin_fn_t;

	typedef enum logic [1:0] {
		PU_18K = 2'b00,
		PU_180K = 2'b01,
		PU_NONE = 2'b10,
		PU_RSVD = 2'b11
	} pullup_sel_t;

	typedef enum logic [1:0] {
		POLY_18K = 2'b00,
		POLY_180K = 2'b01,
		POLY_CUSTOM = 2'b10,
		POLY_RAW = 2'b11
	} poly_sel_t;

	typedef enum logic [1:0] {
		USE_GENERAL = 2'b00,
		USE_CELL_PROT = 2'b01,
		USE_REPORT = 2'b10,
		USE_FET_PROT = 2'b11
	} meas_use_t;
endpackage

/* hdl/pin_drive_decode.sv */
// Per-pin option decoder: output drive and analog measurement controls
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_cfg.svh"

module pin_drive_decode
	import pin_config_pkg::*;
(
	// Setting and pin request
	input wire logic [7:0] setting,
	input wire logic alertCapable,
	input wire logic generalLevel,
	input wire logic alertActive,
	// Output drive controls
	output logic driveLow,
	output logic driveHigh,
	output logic highFromReg1,
	output logic weakPullUp,
	output logic weakPullDown,
	// Analog controls
	output logic analogEnable,
	output pullup_sel_t pullupSel,
	output poly_sel_t polySel,
	output meas_use_t measUse
);
	wire logic [1:0] fnRaw = setting[`FXN_MSB:`FXN_LSB];
	wire logic [5:0] opt = setting[`OPT_MSB:`OPT_LSB];
	// Pins without output capability see every function below analog as unused
	wire logic isGeneral = alertCapable && (fnRaw == FN_GENERAL_OUT);
	wire logic isAlert = alertCapable && (fnRaw == FN_ALERT);
	wire logic isOutput = isGeneral || isAlert;
	// Polarity applies to alert only, never to general output
	wire logic level = isAlert ? (alertActive ^ opt[5]) : generalLevel;
	// Tri-state high is not offered with the regulator rail
	wire logic pushHigh = opt[1] || opt[3];

	assign analogEnable = (fnRaw == FN_ANALOG);
	assign driveLow = isOutput && !level;
	assign driveHigh = isOutput && level && pushHigh;
	assign highFromReg1 = isOutput && opt[3];
	assign weakPullUp = isOutput && opt[2];
	assign weakPullDown = isOutput && opt[0];
	assign pullupSel = analogEnable ? pullup_sel_t'(opt[5:4]) : PU_NONE;
	assign polySel = poly_sel_t'(opt[3:2]);
	assign measUse = meas_use_t'(opt[1:0]);
endmodule
`default_nettype wire

/* test/multifunction_pin_config_test.sv */
// Self-checking bench of the multifunction pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "pin_config_cfg.svh"

module multifunction_pin_config_test;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, er, pinLevel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic iDl, iDh, iReg1, iPu, iPd, iAn, iSw, tAn;
	logic [1:0] iPull, iPoly, iUse, tPull, tPoly, tUse;
	logic [12:0] intVec;
	logic [6:0] ts1Vec;
	int failures = 0;
	int comparisons = 0;
	typedef struct {
		logic [7:0] is, ts;
		logic [1:0] c;
		logic [12:0] ie;
		logic [6:0] te;
	} row_t;
	// Interrupt setting, sense setting, drive control, expected controls
	row_t rows[13] = '{
		'{8'hfc, 8'hfc, 2'h3, 13'h0041, 7'h20}, '{8'h09, 8'hfd, 2'h1, 13'h0840, 7'h20},
		'{8'h09, 8'hfe, 2'h0, 13'h1040, 7'h20}, '{8'h89, 8'h6f, 2'h1, 13'h0840, 7'h5b},
		'{8'h01, 8'h9b, 2'h1, 13'h0040, 7'h66}, '{8'h21, 8'h07, 2'h1, 13'h0c40, 7'h41},
		'{8'h0a, 8'h07, 2'h2, 13'h0840, 7'h41}, '{8'h8a, 8'h07, 2'h2, 13'h1040, 7'h41},
		'{8'h8a, 8'h07, 2'h0, 13'h0840, 7'h41}, '{8'h15, 8'h07, 2'h0, 13'h1340, 7'h41},
		'{8'h6f, 8'h07, 2'h1, 13'h00b6, 7'h41}, '{8'h9b, 8'h07, 2'h1, 13'h00cc, 7'h41},
		'{8'h33, 8'h07, 2'h1, 13'h0098, 7'h41}};

	assign intVec = {iDl, iDh, iReg1, iPu, iPd, iAn, iPull, iPoly, iUse, iSw};
	assign ts1Vec = {tAn, tPull, tPoly, tUse};

	multifunction_pin_config multifunction_pin_config_i (.mclk(mclk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .intDriveLow(iDl),
		.intDriveHigh(iDh), .intHighFromReg1(iReg1), .intWeakPullUp(iPu),
		.intWeakPullDown(iPd), .intAnalogEnable(iAn), .intPullupSel(iPull),
		.intPolySel(iPoly), .intMeasUse(iUse), .intSingleWireEnable(iSw),
		.ts1AnalogEnable(tAn), .ts1PullupSel(tPull), .ts1PolySel(tPoly), .ts1MeasUse(tUse));

	pin_load_model pin_load_model_i (.mclk(mclk), .driveLow(iDl), .driveHigh(iDh),
		.weakPullUp(iPu), .weakPullDown(iPd), .pinLevel(pinLevel));

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			chk(32'h0, 32'h1);
	endtask

	task automatic rstChk();
		apb(1'b0, `OFS_INT_PIN, 32'h0);
		chk(rd, {24'h0, `INT_PIN_RESET});
		apb(1'b0, `OFS_TS1_PIN, 32'h0);
		chk(rd, {24'h0, `TS1_PIN_RESET});
		#1;
		chk({19'h0, intVec}, 32'h0041);
		chk({25'h0, ts1Vec}, 32'h41);
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rstChk();
		// Software never pairs the weak pull-up with the regulator rail
		foreach (rows[i]) begin
			apb(1'b1, `OFS_INT_PIN, {24'h0, rows[i].is});
			apb(1'b1, `OFS_TS1_PIN, {24'h0, rows[i].ts});
			apb(1'b1, `OFS_DRIVE_CTRL, {30'h0, rows[i].c});
			repeat (2) @(posedge mclk);
			#1;
			chk({19'h0, intVec}, {19'h0, rows[i].ie});
			chk({25'h0, ts1Vec}, {25'h0, rows[i].te});
			if (rows[i].ie[12])
				chk({31'h0, pinLevel}, 32'h0);
			if (rows[i].ie[11])
				chk({31'h0, pinLevel}, 32'h1);
			apb(1'b0, `OFS_INT_PIN, 32'h0);
			chk(rd, {24'h0, rows[i].is});
		end
		// Status and drive control read back after the last row
		apb(1'b0, `OFS_INT_STATUS, 32'h0);
		chk(rd, 32'h0000_0020);
		apb(1'b0, `OFS_TS1_STATUS, 32'h0);
		chk(rd, 32'h0000_0050);
		apb(1'b0, `OFS_DRIVE_CTRL, 32'h0);
		chk({rd[30:0], er}, 32'h0000_0002);
		// Upper data bits ignored, unmapped place refused
		apb(1'b1, `OFS_INT_PIN, 32'hffff_ff0a);
		apb(1'b1, 12'h020, 32'h0000_00ff);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b0, `OFS_INT_PIN, 32'h0);
		chk(rd, 32'h0000_000a);
		// Second reset in mid-run
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rstChk();
		tally_and_finish();
	end
endmodule

`default_nettype wire

/* test/pin_load_model.sv */
// Load on the interrupt pin: resolves the pin level from the drive controls
`timescale 1ns/1ps
`default_nettype none

module pin_load_model (
	// Clock
	input wire logic mclk,
	// Drive controls from the block
	input wire logic driveLow,
	input wire logic driveHigh,
	input wire logic weakPullUp,
	input wire logic weakPullDown,
	// Resolved pin
	output logic pinLevel
);
	logic last = 1'b0;

	// Undriven and unpulled pin wanders away from its last level
	always_comb begin
		if (driveLow)
			pinLevel = 1'b0;
		else if (driveHigh)
			pinLevel = 1'b1;
		else if (weakPullUp)
			pinLevel = 1'b1;
		else if (weakPullDown)
			pinLevel = 1'b0;
		else
			pinLevel = !last;
	end

	always @(posedge mclk) begin
		last <= pinLevel;
	end
endmodule

`default_nettype wire
